// *** design/decoder_map.svh ***
`ifndef DECODER_MAP_SVH
`define DECODER_MAP_SVH

// Whole-byte opcodes of the flag-control group
`define OPC_AH_LOAD 8'h9f
`define OPC_AH_STORE 8'h9e
`define OPC_CARRY_SET 8'hf9
`define OPC_DIR_SET 8'hfd
`define OPC_INT_SET 8'hfb

// Upper opcode bits of the arithmetic forms (d and w bits, w bit alone, or short register field dropped)
`define ADD_RM_HI 6'h00
`define ADC_RM_HI 6'h04
`define SUB_RM_HI 6'h0a
`define IMM_GRP_HI 6'h20
`define ADD_ACC_HI 7'h02
`define ADC_ACC_HI 7'h0a
`define SUB_ACC_HI 7'h16
`define INC_RM_HI 7'h7f
`define INC_SHORT_HI 5'h08

// Opcode extension carried in the reg field of the second byte, and the mod field value that marks a register operand
`define EXT_ADD 3'h0
`define EXT_ADC 3'h2
`define EXT_SUB 3'h5
`define EXT_INC 3'h0
`define MOD_REG 2'h3

// Field positions in the opcode byte
`define W_BIT 0
`define D_BIT 1

// Execution counts in core clocks
`define CLK_FLAG 4'h2
`define CLK_AH_STORE 4'h3
`define CLK_INT 4'h8
`define CLK_REG 4'h2
`define CLK_REG_TO_MEM 4'h7
`define CLK_MEM_TO_REG 4'h6
`define CLK_IMM_MEM 4'h7
`define CLK_INC_MEM 4'h6
`define CLK_ILLEGAL 4'h2

// Immediate lengths in bytes
`define IMM_BYTE 3'h1
`define IMM_HALF 3'h2
`define IMM_FULL 3'h4

`endif

// *** design/decoder_pkg.sv ***
package decoder_pkg;

    typedef enum logic [3:0] {
        op_none,
        ah_flag_load_op,
        ah_flag_store_op,
        carry_set_op,
        direction_set_op,
        interrupt_enable_set_op,
        add_op,
        adc_op,
        sub_op,
        inc_op
    } op_e;

    typedef enum logic [2:0] {
        form_none,
        form_rm,
        form_imm_rm,
        form_imm_acc,
        form_reg_short
    } form_e;

    // Gray order along fetch, modrm, immediate, execute
    typedef enum logic [1:0] {
        st_fetch = 2'b00,
        st_modrm = 2'b01,
        st_imm = 2'b11,
        st_exec = 2'b10
    } state_e;

    typedef struct packed {
        op_e op;
        form_e form;
    } decode_s;

endpackage

// *** design/exec_timer.sv ***
`timescale 1ns/1ps
`include "decoder_map.svh"
module exec_timer (
    input wire logic clk,
    input wire logic rst,
    timer_if.timer tmr
);
    logic [3:0] count_reg;
    logic [3:0] count_next;

    // Loaded one short: the load cycle itself is the first clock
    always_comb begin
        count_next = count_reg;
        if (tmr.load) begin
            count_next = tmr.load_count - 4'h1;
        end else if (count_reg != 4'h0) begin
            count_next = count_reg - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= 4'h0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign tmr.done = (count_reg == 4'h1);
    assign tmr.busy = (count_reg != 4'h0);

    a_timer_reload: assert property (@(posedge clk) disable iff (rst)
        tmr.load && tmr.load_count == 4'h8 |=> count_reg == 4'h7 ##6 tmr.done)
        else $error("timer does not run out after load");
endmodule // exec_timer

// *** design/flag_and_add_opcode_decoder.sv ***
`timescale 1ns/1ps
`include "decoder_map.svh"
// Contract
// - 9f is accumulator_high_byte load, two clocks
// - 9e is accumulator_high_byte store, three clocks
// - fd sets direction, f9 carry; two clocks
// - fb sets interrupt enable, eight clocks, privileged
// - short add immediate to accumulator, two clocks
// - add-with-carry register two, to memory seven
module flag_and_add_opcode_decoder
    import decoder_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic prot_mode,
    input wire logic op_size32,
    input wire logic [1:0] cpl,
    input wire logic [1:0] iopl,
    output logic dec_valid,
    output op_e dec_op,
    output form_e dec_form,
    output logic dec_wide,
    output logic dec_reg_dest,
    output logic dec_mem,
    output logic [2:0] dec_reg,
    output logic [2:0] dec_rm,
    output logic [31:0] dec_imm,
    output logic [3:0] dec_clocks,
    output logic dec_priv_fault,
    output logic dec_illegal,
    output logic busy
);
    timer_if tmr ();

    state_e state_reg, state_next;
    op_e op_reg, op_next;
    form_e form_reg, form_next;
    logic wide_reg, wide_next;
    logic dest_reg, dest_next;
    logic sext_reg, sext_next;
    logic mem_reg, mem_next;
    logic [2:0] reg_reg, reg_next;
    logic [2:0] rm_reg, rm_next;
    logic [31:0] imm_reg, imm_next;
    logic [2:0] imm_left_reg, imm_left_next;
    logic [1:0] imm_pos_reg, imm_pos_next;
    logic [3:0] clocks_reg, clocks_next;
    logic fault_reg, fault_next;
    logic illegal_reg, illegal_next;
    logic valid_reg, valid_next;
    logic take;
    logic last_take;
    decode_s dec;

    // First byte sorts opcode into operation and operand form
    function automatic decode_s decode_op(input logic [7:0] b);
        decode_s r;
        r.op = op_none;
        r.form = form_none;
        if (b == `OPC_AH_LOAD) begin
            r.op = ah_flag_load_op;
        end else if (b == `OPC_AH_STORE) begin
            r.op = ah_flag_store_op;
        end else if (b == `OPC_CARRY_SET) begin
            r.op = carry_set_op;
        end else if (b == `OPC_DIR_SET) begin
            r.op = direction_set_op;
        end else if (b == `OPC_INT_SET) begin
            r.op = interrupt_enable_set_op;
        end else if (b[7:2] == `ADD_RM_HI) begin
            r = '{add_op, form_rm};
        end else if (b[7:2] == `ADC_RM_HI) begin
            r = '{adc_op, form_rm};
        end else if (b[7:2] == `SUB_RM_HI) begin
            r = '{sub_op, form_rm};
        end else if (b[7:2] == `IMM_GRP_HI) begin
            r = '{op_none, form_imm_rm}; // Operation comes with modrm
        end else if (b[7:1] == `ADD_ACC_HI) begin
            r = '{add_op, form_imm_acc};
        end else if (b[7:1] == `ADC_ACC_HI) begin
            r = '{adc_op, form_imm_acc};
        end else if (b[7:1] == `SUB_ACC_HI) begin
            r = '{sub_op, form_imm_acc};
        end else if (b[7:1] == `INC_RM_HI) begin
            r = '{inc_op, form_rm};
        end else if (b[7:3] == `INC_SHORT_HI) begin
            r = '{inc_op, form_reg_short};
        end
        return r;
    endfunction

    // Execution count from operation, form and memory direction
    function automatic logic [3:0] exec_clocks(input op_e op,
            input form_e form, input logic mem, input logic d);
        logic [3:0] c;
        c = `CLK_REG;
        case (op)
            ah_flag_load_op: c = `CLK_FLAG;
            ah_flag_store_op: c = `CLK_AH_STORE;
            carry_set_op, direction_set_op: c = `CLK_FLAG;
            interrupt_enable_set_op: c = `CLK_INT;
            inc_op: c = mem ? `CLK_INC_MEM : `CLK_REG;
            op_none: c = `CLK_ILLEGAL;
            default: begin
                if (form == form_rm && mem) begin
                    c = d ? `CLK_MEM_TO_REG : `CLK_REG_TO_MEM;
                end else if (form == form_imm_rm && mem) begin
                    c = `CLK_IMM_MEM;
                end else begin
                    c = `CLK_REG;
                end
            end
        endcase
        return c;
    endfunction

    // Immediate length: byte operand or sign-extended byte is short
    function automatic logic [2:0] imm_len(input logic w, input logic s,
            input logic size32);
        logic [2:0] n;
        n = `IMM_BYTE;
        if (w && !s) begin
            n = size32 ? `IMM_FULL : `IMM_HALF;
        end
        return n;
    endfunction

    assign in_ready = (state_reg != st_exec);
    assign take = in_valid && in_ready;
    assign dec = decode_op(in_data);
    assign last_take = take && (state_reg == st_imm)
        && (imm_left_reg == 3'h1);

    // Byte collection and execution sequencing
    always_comb begin
        logic [31:0] imm_v;
        imm_v = imm_reg;
        state_next = state_reg;
        op_next = op_reg;
        form_next = form_reg;
        wide_next = wide_reg;
        dest_next = dest_reg;
        sext_next = sext_reg;
        mem_next = mem_reg;
        reg_next = reg_reg;
        rm_next = rm_reg;
        imm_next = imm_reg;
        imm_left_next = imm_left_reg;
        imm_pos_next = imm_pos_reg;
        clocks_next = clocks_reg;
        fault_next = fault_reg;
        illegal_next = illegal_reg;
        valid_next = 1'b0;
        tmr.load = 1'b0;
        tmr.load_count = clocks_reg;
        case (state_reg)
            st_fetch: begin
                if (take) begin
                    op_next = dec.op;
                    form_next = dec.form;
                    wide_next = in_data[`W_BIT];
                    dest_next = in_data[`D_BIT];
                    sext_next = 1'b0;
                    mem_next = 1'b0;
                    reg_next = 3'h0;
                    rm_next = 3'h0;
                    imm_next = 32'h0;
                    imm_pos_next = 2'h0;
                    fault_next = 1'b0;
                    illegal_next = (dec.op == op_none)
                        && (dec.form == form_none);
                    imm_left_next = imm_len(in_data[`W_BIT], 1'b0, op_size32);
                    if (dec.form == form_imm_rm) begin
                        // Bit 1 is the sign-extend bit here; r/m is target
                        sext_next = in_data[`D_BIT];
                        dest_next = 1'b0;
                        imm_left_next = imm_len(in_data[`W_BIT],
                            in_data[`D_BIT], op_size32);
                    end else if (dec.form == form_imm_acc) begin
                        dest_next = 1'b1; // Accumulator is the target
                    end else if (dec.form == form_reg_short) begin
                        wide_next = 1'b1;
                        dest_next = 1'b1;
                        reg_next = in_data[2:0];
                    end else if (dec.form == form_none) begin
                        wide_next = 1'b0;
                        dest_next = 1'b0;
                    end
                    // Privilege check only applies in protected mode
                    if (dec.op == interrupt_enable_set_op) begin
                        fault_next = prot_mode && (cpl > iopl);
                    end
                    if (dec.form == form_rm || dec.form == form_imm_rm) begin
                        state_next = st_modrm;
                    end else if (dec.form == form_imm_acc) begin
                        state_next = st_imm;
                    end else begin
                        clocks_next = exec_clocks(dec.op, dec.form, 1'b0,
                            in_data[`D_BIT]);
                        tmr.load = 1'b1;
                        tmr.load_count = clocks_next;
                        state_next = st_exec;
                    end
                end
            end
            st_modrm: begin
                if (take) begin
                    mem_next = (in_data[7:6] != `MOD_REG);
                    reg_next = in_data[5:3];
                    rm_next = in_data[2:0];
                    if (form_reg == form_imm_rm) begin
                        if (in_data[5:3] == `EXT_ADD) begin
                            op_next = add_op;
                        end else if (in_data[5:3] == `EXT_ADC) begin
                            op_next = adc_op;
                        end else if (in_data[5:3] == `EXT_SUB) begin
                            op_next = sub_op;
                        end else begin
                            illegal_next = 1'b1;
                        end
                    end else if (op_reg == inc_op) begin
                        illegal_next = (in_data[5:3] != `EXT_INC);
                    end
                    if (form_reg == form_imm_rm && !illegal_next) begin
                        state_next = st_imm;
                    end else begin
                        clocks_next = illegal_next ? `CLK_ILLEGAL
                            : exec_clocks(op_reg, form_reg, mem_next,
                                dest_reg);
                        tmr.load = 1'b1;
                        tmr.load_count = clocks_next;
                        state_next = st_exec;
                    end
                end
            end
            st_imm: begin
                if (take) begin
                    imm_v[{imm_pos_reg, 3'h0} +: 8] = in_data;
                    imm_pos_next = imm_pos_reg + 2'h1;
                    imm_left_next = imm_left_reg - 3'h1;
                    if (imm_left_reg == 3'h1) begin
                        // Sign-extend a short immediate for a wide operand
                        if (sext_reg && wide_reg) begin
                            imm_v = {{24{imm_v[7]}}, imm_v[7:0]};
                        end
                        clocks_next = exec_clocks(op_reg, form_reg, mem_reg,
                            dest_reg);
                        tmr.load = 1'b1;
                        tmr.load_count = clocks_next;
                        state_next = st_exec;
                    end
                    imm_next = imm_v;
                end
            end
            st_exec: begin
                if (tmr.done) begin
                    valid_next = 1'b1;
                    state_next = st_fetch;
                end
            end
            default: state_next = st_fetch;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= st_fetch;
            op_reg <= op_none;
            form_reg <= form_none;
            wide_reg <= 1'b0;
            dest_reg <= 1'b0;
            sext_reg <= 1'b0;
            mem_reg <= 1'b0;
            reg_reg <= 3'h0;
            rm_reg <= 3'h0;
            imm_reg <= 32'h0;
            imm_left_reg <= 3'h0;
            imm_pos_reg <= 2'h0;
            clocks_reg <= 4'h0;
            fault_reg <= 1'b0;
            illegal_reg <= 1'b0;
            valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            form_reg <= form_next;
            wide_reg <= wide_next;
            dest_reg <= dest_next;
            sext_reg <= sext_next;
            mem_reg <= mem_next;
            reg_reg <= reg_next;
            rm_reg <= rm_next;
            imm_reg <= imm_next;
            imm_left_reg <= imm_left_next;
            imm_pos_reg <= imm_pos_next;
            clocks_reg <= clocks_next;
            fault_reg <= fault_next;
            illegal_reg <= illegal_next;
            valid_reg <= valid_next;
        end
    end

    exec_timer u_timer (
        .clk(clk),
        .rst(rst),
        .tmr(tmr.timer)
    );

    // Decoded fields are held registers; valid marks the finished count
    assign dec_valid = valid_reg;
    assign dec_op = op_reg;
    assign dec_form = form_reg;
    assign dec_wide = wide_reg;
    assign dec_reg_dest = dest_reg;
    assign dec_mem = mem_reg;
    assign dec_reg = reg_reg;
    assign dec_rm = rm_reg;
    assign dec_imm = imm_reg;
    assign dec_clocks = clocks_reg;
    assign dec_priv_fault = fault_reg;
    assign dec_illegal = illegal_reg;
    assign busy = (state_reg == st_exec);

    a_ah_load_time: assert property (@(posedge clk) disable iff (rst)
        take && state_reg == st_fetch && in_data == 8'h9f |=>
        !dec_valid ##1 dec_valid && dec_op == ah_flag_load_op)
        else $error("ah load not done in two clocks");
    a_ah_store_time: assert property (@(posedge clk) disable iff (rst)
        take && state_reg == st_fetch && in_data == 8'h9e |->
        ##1 (!dec_valid) [*2] ##1 dec_valid && dec_op == ah_flag_store_op)
        else $error("ah store not done in three clocks");
    a_flag_set_time: assert property (@(posedge clk) disable iff (rst)
        take && state_reg == st_fetch && (in_data == 8'hfd
        || in_data == 8'hf9) |-> ##2 dec_valid && dec_clocks == 4'h2
        && (dec_op == direction_set_op) == $past(in_data[2], 2))
        else $error("direction or carry set decoded wrong");
    a_int_set_time: assert property (@(posedge clk) disable iff (rst)
        take && state_reg == st_fetch && in_data == 8'hfb |=>
        busy [*7] ##1 dec_valid && dec_op == interrupt_enable_set_op)
        else $error("interrupt enable set not done in eight clocks");
    a_int_priv_check: assert property (@(posedge clk) disable iff (rst)
        dec_valid && dec_op == interrupt_enable_set_op |->
        dec_priv_fault == $past(prot_mode && cpl > iopl, 8))
        else $error("privilege fault wrong");
    a_acc_add_time: assert property (@(posedge clk) disable iff (rst)
        dec_valid && dec_op == add_op && dec_form == form_imm_acc |->
        $past(last_take, 2) && dec_clocks == 4'h2 && dec_reg_dest)
        else $error("accumulator add timing wrong");
    a_adc_clocks: assert property (@(posedge clk) disable iff (rst)
        dec_valid && dec_op == adc_op && dec_form == form_rm |->
        dec_clocks == (!dec_mem ? 4'h2 : (dec_reg_dest ? 4'h6 : 4'h7)))
        else $error("add-with-carry count wrong");
    a_operand_bits: assert property (@(posedge clk) disable iff (rst)
        take && state_reg == st_fetch && dec.form == form_rm |=>
        wide_reg == $past(in_data[0]) && dest_reg == $past(in_data[1]))
        else $error("width or direction bit lost");

    c_ah_load: cover property (@(posedge clk) dec_valid
        && dec_op == ah_flag_load_op);
    c_int_fault: cover property (@(posedge clk) dec_valid
        && dec_priv_fault);
    c_adc_mem: cover property (@(posedge clk) dec_valid && dec_op == adc_op
        && dec_mem && !dec_reg_dest);
    c_acc_add: cover property (@(posedge clk) dec_valid
        && dec_form == form_imm_acc);
endmodule // flag_and_add_opcode_decoder

// *** design/timer_if.sv ***
`timescale 1ns/1ps
interface timer_if;
    logic load;
    logic [3:0] load_count;
    logic done;
    logic busy;

    modport ctrl (output load, output load_count, input done, input busy);
    modport timer (input load, input load_count, output done, output busy);
endinterface

// *** tb/fetch_model.sv ***
`timescale 1ns/1ps
// Instruction fetch stand-in: queued bytes, random pauses after each instruction's last byte
module fetch_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_ready,
    output logic [7:0] in_data,
    output logic in_valid
);
    logic [8:0] byte_q[$];
    logic taken;
    int gap;

    initial begin
        in_valid = 1'b0;
        in_data = 8'h00;
        taken = 1'b0;
        gap = 0;
    end

    // Whole instruction queued at once, so its bytes go out back to back
    task automatic push(input logic [7:0] b, input logic last);
        byte_q.push_back({last, b});
    endtask

    // Handshake as the decoder sees it at the rising edge
    always @(posedge clk) begin
        taken <= in_valid && in_ready && !rst;
    end

    // Idle data toggles so a stale byte never passes for a fresh one
    always @(negedge clk) begin
        if (taken) begin
            if (byte_q[0][8]) begin
                gap = $urandom_range(0, 2);
            end
            void'(byte_q.pop_front());
        end
        if (!rst && gap == 0 && byte_q.size() > 0) begin
            in_valid = 1'b1;
            in_data = byte_q[0][7:0];
        end else begin
            if (gap > 0) begin
                gap--;
            end
            in_valid = 1'b0;
            in_data = ~in_data;
        end
    end
endmodule // fetch_model

// *** tb/tb_flag_and_add_opcode_decoder.sv ***
`timescale 1ns/1ps
`define CHK(name, exp, got) begin \
    samples_checked++; \
    if ((exp) !== (got)) begin \
        n_mismatch++; \
        $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); \
    end \
end
module tb_flag_and_add_opcode_decoder
    import decoder_pkg::*;
;
    typedef struct {
        op_e op;
        form_e form;
        logic wide, regd, mem, fault, illegal;
        logic [2:0] reg_f, rm;
        logic [31:0] imm;
        logic [3:0] clocks;
        int nbytes, chk;
    } exp_s;

    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] in_data;
    logic in_valid, in_ready, prot_mode = 0, op_size32 = 0;
    logic [1:0] cpl = 2'h0, iopl = 2'h0;
    logic dec_valid, dec_wide, dec_reg_dest, dec_mem;
    logic dec_priv_fault, dec_illegal, busy;
    op_e dec_op;
    form_e dec_form;
    logic [2:0] dec_reg, dec_rm;
    logic [31:0] dec_imm;
    logic [3:0] dec_clocks;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, t_last = 0, nb = 0;
    int hold = 0;
    exp_s exp_q[$];
    exp_s e;
    logic [7:0] flag_ops[5] = '{8'h9f, 8'h9e, 8'hf9, 8'hfd, 8'hfb};
    logic [7:0] acc_ops[6] = '{8'h04, 8'h05, 8'h14, 8'h15, 8'h2c, 8'h2d};
    logic [7:0] rm_ops[8] = '{8'h00, 8'h03, 8'h11, 8'h12, 8'h29, 8'h2a,
        8'hfe, 8'hff};
    logic [2:0] exts[5] = '{3'h0, 3'h2, 3'h5, 3'h1, 3'h3};

    always #5 clk = ~clk;

    fetch_model u_fetch (.clk(clk), .rst(rst), .in_ready(in_ready),
        .in_data(in_data), .in_valid(in_valid));

    flag_and_add_opcode_decoder u_flag_and_add_opcode_decoder (
        .clk(clk), .rst(rst), .in_data(in_data), .in_valid(in_valid),
        .in_ready(in_ready), .prot_mode(prot_mode), .op_size32(op_size32),
        .cpl(cpl), .iopl(iopl), .dec_valid(dec_valid), .dec_op(dec_op),
        .dec_form(dec_form), .dec_wide(dec_wide),
        .dec_reg_dest(dec_reg_dest), .dec_mem(dec_mem), .dec_reg(dec_reg),
        .dec_rm(dec_rm), .dec_imm(dec_imm), .dec_clocks(dec_clocks),
        .dec_priv_fault(dec_priv_fault), .dec_illegal(dec_illegal),
        .busy(busy));

    task automatic finish_test();
        $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reference decode: expected fields and byte count of one instruction
    task automatic send(input logic [7:0] opc, input logic [7:0] mr,
                        input logic [31:0] iv);
        exp_s x;
        int ilen;
        logic use_mr;
        x = '{op: op_none, form: form_none, wide: opc[0], regd: 1'b1,
              mem: mr[7:6] != 2'b11, fault: 1'b0, illegal: 1'b0,
              reg_f: mr[5:3], rm: mr[2:0], imm: 32'h0, clocks: 4'h2,
              nbytes: 1, chk: 0};
        ilen = 0;
        use_mr = 1'b0;
        casez (opc)
            8'h9f: x.op = ah_flag_load_op;
            8'h9e: begin
                x.op = ah_flag_store_op;
                x.clocks = 4'h3;
            end
            8'hf9: x.op = carry_set_op;
            8'hfd: x.op = direction_set_op;
            8'hfb: begin
                x.op = interrupt_enable_set_op;
                x.clocks = 4'h8;
                x.fault = prot_mode && (cpl > iopl);
            end
            8'b000?010?, 8'b0010110?: begin
                x.op = opc[5] ? sub_op : (opc[4] ? adc_op : add_op);
                x.form = form_imm_acc;
                ilen = opc[0] ? (op_size32 ? 4 : 2) : 1;
                x.chk = 'h0b;
            end
            8'b000?00??, 8'b001010??, 8'b1111111?: begin
                x.op = opc[5] ? sub_op : (opc[4] ? adc_op : add_op);
                if (opc[7]) x.op = inc_op;
                x.illegal = opc[7] && mr[5:3] != 3'h0;
                x.form = form_rm;
                x.regd = opc[1];
                x.clocks = !x.mem ? 4'h2 : (opc[1] ? 4'h6 : 4'h7);
                use_mr = 1'b1;
                x.chk = 'h17;
            end
            8'b100000??: begin
                use_mr = 1'b1;
                x.form = form_imm_rm;
                x.regd = 1'b0;
                x.clocks = x.mem ? 4'h7 : 4'h2;
                ilen = (!opc[0] || opc[1]) ? 1 : (op_size32 ? 4 : 2);
                x.chk = 'h1f;
                case (mr[5:3])
                    3'h0: x.op = add_op;
                    3'h2: x.op = adc_op;
                    3'h5: x.op = sub_op;
                    default: begin
                        x.illegal = 1'b1;
                        ilen = 0;
                        x.chk = 0;
                    end
                endcase
            end
            8'b01000???: begin
                x.op = inc_op;
                x.form = form_reg_short;
                x.reg_f = opc[2:0];
                x.chk = 'h12;
            end
            default: x.illegal = 1'b1;
        endcase
        if (x.illegal) x.clocks = 4'h2;
        // Short immediates widen by sign only for the sign-extend form
        if (ilen == 1) begin
            x.imm = (opc == 8'h83) ? {{24{iv[7]}}, iv[7:0]} : {24'h0, iv[7:0]};
        end else begin
            x.imm = (ilen == 2) ? {16'h0, iv[15:0]} : iv;
        end
        x.nbytes = 1 + int'(use_mr) + ilen;
        exp_q.push_back(x);
        u_fetch.push(opc, x.nbytes == 1);
        if (use_mr) begin
            u_fetch.push(mr, x.nbytes == 2);
        end
        for (int i = 0; i < ilen; i++) begin
            u_fetch.push(iv[8*i +: 8], i == ilen - 1);
        end
    endtask

    // Bounded wait until every queued instruction has completed
    task automatic drain();
        for (int i = 0; exp_q.size() > 0; i++) begin
            if (i > 500) begin
                n_mismatch++;
                finish_test();
            end
            @(posedge clk);
        end
    endtask

    // Completion first, so a take in the same cycle counts for the next one
    always @(posedge clk) begin
        cyc++;
        if (rst) begin
            nb = 0;
            hold = 0;
        end else begin
            `CHK("in_ready", hold == 0, in_ready)
            `CHK("busy", hold != 0, busy)
            if (hold > 0) hold--;
            if (dec_valid !== 1'b0) begin
                if (exp_q.size() == 0) begin
                    `CHK("spurious", 1'b0, dec_valid)
                end else begin
                    e = exp_q.pop_front();
                    `CHK("latency", int'(e.clocks), cyc - t_last)
                    `CHK("clocks", e.clocks, dec_clocks)
                    `CHK("illegal", e.illegal, dec_illegal)
                    `CHK("fault", e.fault, dec_priv_fault)
                    if (!e.illegal) begin
                        `CHK("op", e.op, dec_op)
                        `CHK("form", e.form, dec_form)
                    end
                    if (e.chk[0]) `CHK("wide", e.wide, dec_wide)
                    if (e.chk[1]) `CHK("reg_dest", e.regd, dec_reg_dest)
                    if (e.chk[2]) `CHK("mem", e.mem, dec_mem)
                    if (e.chk[2]) `CHK("rm", e.rm, dec_rm)
                    if (e.chk[3]) `CHK("imm", e.imm, dec_imm)
                    if (e.chk[4]) `CHK("reg", e.reg_f, dec_reg)
                end
            end
            if (in_valid && in_ready && exp_q.size() > 0) begin
                nb++;
                if (nb == exp_q[0].nbytes) begin
                    t_last = cyc;
                    hold = int'(exp_q[0].clocks) - 1;
                    nb = 0;
                end
            end
        end
    end

    initial begin
        void'($urandom(32'h6b13));
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        // Every mode: real/protected, 16/32-bit, privilege faulting or not
        for (int m = 0; m < 8; m++) begin
            @(negedge clk);
            prot_mode = m[0];
            op_size32 = m[1];
            cpl = m[2] ? 2'h3 : 2'h0;
            iopl = m[2] ? 2'h0 : 2'h3;
            foreach (flag_ops[i]) send(flag_ops[i], 8'h00, 32'h0);
            foreach (acc_ops[i]) send(acc_ops[i], 8'h00, $urandom());
            foreach (rm_ops[i]) begin
                send(rm_ops[i], {2'b11, 6'($urandom())}, 32'h0);
                send(rm_ops[i], {2'($urandom_range(0, 2)), 6'($urandom())},
                     32'h0);
            end
            for (int o = 0; o < 4; o++) begin
                foreach (exts[i]) begin
                    send(8'h80 | 8'(o), {2'($urandom()), exts[i],
                         3'($urandom())}, $urandom());
                end
            end
            send(8'h40 | 8'($urandom_range(0, 7)), 8'h00, 32'h0);
            send(8'h90, 8'h00, 32'h0);
            drain();
        end
        // Reset in the middle of a long execute count
        send(8'hfb, 8'h00, 32'h0);
        repeat (4) @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        exp_q.delete();
        u_fetch.byte_q.delete();
        `CHK("rst_ready", 1'b1, in_ready)
        `CHK("rst_busy", 1'b0, busy)
        `CHK("rst_valid", 1'b0, dec_valid)
        `CHK("rst_op", op_none, dec_op)
        rst = 1'b0;
        send(8'h9f, 8'h00, 32'h0);
        send(8'hf9, 8'h00, 32'h0);
        drain();
        finish_test();
    end
endmodule // tb_flag_and_add_opcode_decoder
